/* File: shared/wdt_pkg.sv */
// How it works
// - After supply recovery and init time, four reset-delay cycles, then both outputs rise.
// - Enable high at reset release starts watchdog timebase cycling at once.
// - Enable low at release keeps watchdog idle until enable rises.
// - Thirty-two watchdog cycles without a kick pull the fault output low.
// - A qualifying kick edge while the timebase runs clears the cycle counter.
// - A kick starts a discharge; cycling resumes only after discharge completes.
// - Qualifying edge is fixed: rising only, falling only, or both.
// - Enable falling while running discharges the timebase and clears the counter.
// - Enable rising again restarts cycling from a cleared count.
// - Window mode: second edge within discharge plus one cycle pulls fault low.
// - Enable low then high after a kick cancels double-pulse detection.
// - Both-edge parts flag a double pulse only for rising then falling.
// - Low voltage pulls outputs low until init time and four reset-delay cycles after recovery.
// - Low voltage acts whatever the timebases, enable and mode inputs do.
// - Enable, kick and mode inputs reject pulses up to 200 ns wide.
// - Unfinished reset-delay discharge at recovery postpones the reset-delay cycles.
`default_nettype none

package wdt_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int FILT_NS = 200;
    localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int FW = 5;
    localparam int TW = 20;
    localparam int RD_CYCLE_NS = 3625000;
    localparam int RD_CYCLE_CYC = RD_CYCLE_NS / 1000 * CLK_MHZ;
    localparam int WD_CYCLE_NS = 768750;
    localparam int WD_CYCLE_CYC = WD_CYCLE_NS * CLK_MHZ / 1000;
    localparam int WD_DISCH_CYC = 64;
    localparam int RD_DISCH_CYC = 64;
    localparam int INIT_NS = 100000;
    localparam int INIT_CYC = INIT_NS * CLK_MHZ / 1000;
    localparam int RD_CYCLES = 4;
    localparam int WD_CYCLES = 32;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_MASK = 8'h04;
    localparam logic [7:0] ADR_STATE = 8'h08;
    localparam logic [7:0] ADR_CTRL = 8'h0c;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_DPULSE = 1;
    localparam int EV_LOWV = 2;
    localparam int EV_RELEASE = 3;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef enum logic [1:0] {
        SUP_LOW = 2'h0,
        SUP_INIT = 2'h1,
        SUP_RDLY = 2'h3,
        SUP_RUN = 2'h2
    } sup_e;

    typedef enum logic [1:0] {
        WD_IDLE = 2'h0,
        WD_CHG = 2'h1,
        WD_DIS = 2'h3,
        WD_FLT = 2'h2
    } wd_e;

    typedef struct packed {
        logic mode;
        logic kick;
        logic enable;
    } pin_s;

endpackage

`default_nettype wire

/* File: hw/supervisory_watchdog_with_reset.sv */
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none

module supervisory_watchdog_with_reset #(
    parameter logic [1:0] EDGE_SEL = wdt_pkg::EDGE_RISE,
    parameter bit HAS_RST_OUT = 1'b0,
    parameter logic [19:0] RD_PERIOD = 20'(wdt_pkg::RD_CYCLE_CYC),
    parameter logic [19:0] WD_PERIOD = 20'(wdt_pkg::WD_CYCLE_CYC),
    parameter logic [19:0] WD_DISCH = 20'(wdt_pkg::WD_DISCH_CYC),
    parameter logic [19:0] RD_DISCH = 20'(wdt_pkg::RD_DISCH_CYC),
    parameter logic [19:0] INIT_PERIOD = 20'(wdt_pkg::INIT_CYC)
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset, high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic supply_ok_i, // Supply above release level
    input wire logic enable_i, // Watchdog enable pin
    input wire logic watchdog_kick_in_i, // Kick pin
    input wire logic mode_timeout_i, // High: time-out mode when HAS_RST_OUT is 0
    output logic watchdog_fault_out_n_o, // Fault, low active
    output logic reset_out_n_o, // Reset, low active
    output logic irq_o // Interrupt level
);

    // ----------------------------------------
    // Synchronisers and noise filters
    // ----------------------------------------
    logic [3:0] raw;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [2:0] flt_r;
    logic [2:0] flt_nxt;
    logic [wdt_pkg::FW-1:0] fcnt_r [3];
    logic [wdt_pkg::FW-1:0] fcnt_nxt [3];
    wdt_pkg::pin_s pin;
    logic sup_ok;

    assign raw = {supply_ok_i, mode_timeout_i, watchdog_kick_in_i, enable_i};
    assign sup_ok = s2_r[3];
    assign pin = wdt_pkg::pin_s'(flt_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_flt
        always_comb begin
            flt_nxt[i] = flt_r[i];
            fcnt_nxt[i] = '0;
            if (s2_r[i] != flt_r[i]) begin
                if (fcnt_r[i] == wdt_pkg::FW'(wdt_pkg::FILT_CYC - 1)) begin
                    flt_nxt[i] = s2_r[i];
                end else begin
                    fcnt_nxt[i] = fcnt_r[i] + 5'h1;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                flt_r[i] <= 1'b0;
                fcnt_r[i] <= '0;
            end else begin
                flt_r[i] <= flt_nxt[i];
                fcnt_r[i] <= fcnt_nxt[i];
            end
        end
    end

    // ----------------------------------------
    // Kick edge detection
    // ----------------------------------------
    logic kick_d_r;
    logic kick_sw_r;
    logic k_rise;
    logic k_fall;
    logic qual;
    logic window;

    assign k_rise = pin.kick && !kick_d_r;
    assign k_fall = !pin.kick && kick_d_r;
    assign qual = (EDGE_SEL[0] && k_rise) || (EDGE_SEL[1] && k_fall) || kick_sw_r;
    assign window = HAS_RST_OUT ? 1'b1 : !pin.mode;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kick_d_r <= 1'b0;
        end else begin
            kick_d_r <= pin.kick;
        end
    end

    // ----------------------------------------
    // Supply supervisor
    // ----------------------------------------
    wdt_pkg::sup_e sup_r;
    wdt_pkg::sup_e sup_nxt;
    logic [19:0] rd_tick_r;
    logic [19:0] rd_tick_nxt;
    logic [2:0] rd_cnt_r;
    logic [2:0] rd_cnt_nxt;
    logic [19:0] init_r;
    logic [19:0] init_nxt;
    logic rd_dis_done;

    assign rd_dis_done = rd_tick_r == RD_DISCH - 20'd1;

    always_comb begin
        sup_nxt = sup_r;
        rd_tick_nxt = rd_tick_r;
        rd_cnt_nxt = rd_cnt_r;
        init_nxt = init_r;
        unique case (sup_r)
            wdt_pkg::SUP_LOW: begin
                if (!rd_dis_done) begin
                    rd_tick_nxt = rd_tick_r + 20'd1;
                end
                if (sup_ok) begin
                    sup_nxt = wdt_pkg::SUP_INIT;
                    init_nxt = '0;
                end
            end
            wdt_pkg::SUP_INIT: begin
                if (!rd_dis_done) begin
                    rd_tick_nxt = rd_tick_r + 20'd1;
                end
                if (init_r != INIT_PERIOD - 20'd1) begin
                    init_nxt = init_r + 20'd1;
                end else if (rd_dis_done) begin
                    sup_nxt = wdt_pkg::SUP_RDLY;
                    rd_tick_nxt = '0;
                    rd_cnt_nxt = '0;
                end
            end
            wdt_pkg::SUP_RDLY: begin
                if (rd_tick_r == RD_PERIOD - 20'd1) begin
                    rd_tick_nxt = '0;
                    if (rd_cnt_r == 3'(wdt_pkg::RD_CYCLES - 1)) begin
                        sup_nxt = wdt_pkg::SUP_RUN;
                    end else begin
                        rd_cnt_nxt = rd_cnt_r + 3'h1;
                    end
                end else begin
                    rd_tick_nxt = rd_tick_r + 20'd1;
                end
            end
            wdt_pkg::SUP_RUN: begin
                rd_tick_nxt = '0;
            end
        endcase
        if (!sup_ok && sup_r != wdt_pkg::SUP_LOW) begin
            sup_nxt = wdt_pkg::SUP_LOW;
            if (sup_r != wdt_pkg::SUP_INIT) begin
                rd_tick_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sup_r <= wdt_pkg::SUP_LOW;
            rd_tick_r <= '0;
            rd_cnt_r <= '0;
            init_r <= '0;
        end else begin
            sup_r <= sup_nxt;
            rd_tick_r <= rd_tick_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            init_r <= init_nxt;
        end
    end

    // ----------------------------------------
    // Watchdog timebase
    // ----------------------------------------
    wdt_pkg::wd_e wd_r;
    wdt_pkg::wd_e wd_nxt;
    logic [19:0] wd_tick_r;
    logic [19:0] wd_tick_nxt;
    logic [5:0] wd_cnt_r;
    logic [5:0] wd_cnt_nxt;
    logic [19:0] dp_r;
    logic [19:0] dp_nxt;
    logic last_rise_r;
    logic last_rise_nxt;
    logic run;
    logic dp_hit;
    logic ev_to;
    logic ev_dp;

    assign run = sup_r == wdt_pkg::SUP_RUN && sup_ok;
    assign dp_hit = qual && dp_r != '0 && window
        && (EDGE_SEL != wdt_pkg::EDGE_BOTH || (last_rise_r && k_fall));

    always_comb begin
        wd_nxt = wd_r;
        wd_tick_nxt = wd_tick_r;
        wd_cnt_nxt = wd_cnt_r;
        dp_nxt = dp_r;
        last_rise_nxt = last_rise_r;
        ev_to = 1'b0;
        ev_dp = 1'b0;
        if (dp_r != '0) begin
            dp_nxt = dp_r - 20'd1;
        end
        unique case (wd_r)
            wdt_pkg::WD_IDLE: begin
                if (pin.enable) begin
                    wd_nxt = wdt_pkg::WD_CHG;
                    wd_tick_nxt = '0;
                    wd_cnt_nxt = '0;
                end
            end
            wdt_pkg::WD_CHG, wdt_pkg::WD_DIS: begin
                if (!pin.enable) begin
                    wd_cnt_nxt = '0;
                    dp_nxt = '0;
                    if (wd_r == wdt_pkg::WD_CHG) begin
                        wd_nxt = wdt_pkg::WD_DIS;
                        wd_tick_nxt = '0;
                    end else if (wd_tick_r == WD_DISCH - 20'd1) begin
                        wd_nxt = wdt_pkg::WD_IDLE;
                    end else begin
                        wd_tick_nxt = wd_tick_r + 20'd1;
                    end
                end else if (dp_hit) begin
                    wd_nxt = wdt_pkg::WD_FLT;
                    wd_tick_nxt = '0;
                    wd_cnt_nxt = '0;
                    dp_nxt = '0;
                    ev_dp = 1'b1;
                end else if (qual) begin
                    wd_nxt = wdt_pkg::WD_DIS;
                    wd_tick_nxt = '0;
                    wd_cnt_nxt = '0;
                    dp_nxt = 20'(WD_DISCH + WD_PERIOD);
                    last_rise_nxt = k_rise;
                end else if (wd_r == wdt_pkg::WD_DIS) begin
                    if (wd_tick_r == WD_DISCH - 20'd1) begin
                        wd_nxt = wdt_pkg::WD_CHG;
                        wd_tick_nxt = '0;
                    end else begin
                        wd_tick_nxt = wd_tick_r + 20'd1;
                    end
                end else if (wd_tick_r == WD_PERIOD - 20'd1) begin
                    wd_tick_nxt = '0;
                    if (wd_cnt_r == 6'(wdt_pkg::WD_CYCLES - 1)) begin
                        wd_nxt = wdt_pkg::WD_FLT;
                        wd_cnt_nxt = '0;
                        ev_to = 1'b1;
                    end else begin
                        wd_cnt_nxt = wd_cnt_r + 6'h1;
                    end
                end else begin
                    wd_tick_nxt = wd_tick_r + 20'd1;
                end
            end
            wdt_pkg::WD_FLT: begin
                // Fault held for four reset-delay cycles
                if (wd_tick_r == RD_PERIOD - 20'd1) begin
                    wd_tick_nxt = '0;
                    if (wd_cnt_r == 6'(wdt_pkg::RD_CYCLES - 1)) begin
                        wd_nxt = wdt_pkg::WD_IDLE;
                        wd_cnt_nxt = '0;
                    end else begin
                        wd_cnt_nxt = wd_cnt_r + 6'h1;
                    end
                end else begin
                    wd_tick_nxt = wd_tick_r + 20'd1;
                end
            end
        endcase
        if (!run) begin
            wd_nxt = wdt_pkg::WD_IDLE;
            wd_tick_nxt = '0;
            wd_cnt_nxt = '0;
            dp_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_r <= wdt_pkg::WD_IDLE;
            wd_tick_r <= '0;
            wd_cnt_r <= '0;
            dp_r <= '0;
            last_rise_r <= 1'b0;
        end else begin
            wd_r <= wd_nxt;
            wd_tick_r <= wd_tick_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            dp_r <= dp_nxt;
            last_rise_r <= last_rise_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, registers and interrupt
    // ----------------------------------------
    logic [3:0] status_r;
    logic [3:0] status_nxt;
    logic [3:0] mask_r;
    logic [3:0] mask_nxt;
    logic [3:0] ev;
    logic [31:0] rdata;
    logic [31:0] dat_nxt;
    logic [7:0] adr;
    logic hit;
    logic wr;
    logic kick_sw_nxt;
    logic wdo_nxt;
    logic rst_n_nxt;

    assign adr = {wb_adr_i[7:2], 2'b00};
    assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = hit && wb_we_i && wb_sel_i[0];
    assign ev = {sup_r == wdt_pkg::SUP_RDLY && sup_nxt == wdt_pkg::SUP_RUN,
        sup_r != wdt_pkg::SUP_LOW && sup_nxt == wdt_pkg::SUP_LOW, ev_dp, ev_to};

    always_comb begin
        unique case (adr)
            wdt_pkg::ADR_STATUS: rdata = {28'h0, status_r};
            wdt_pkg::ADR_MASK: rdata = {28'h0, mask_r};
            wdt_pkg::ADR_STATE: rdata = {20'h0, reset_out_n_o, watchdog_fault_out_n_o, wd_cnt_r, wd_r, sup_r};
            default: rdata = 32'h0;
        endcase
        dat_nxt = (hit && !wb_we_i) ? rdata : 32'h0;
        status_nxt = status_r;
        mask_nxt = mask_r;
        kick_sw_nxt = 1'b0;
        if (wr && adr == wdt_pkg::ADR_STATUS) begin
            status_nxt = status_r & ~wb_dat_i[3:0];
        end
        if (wr && adr == wdt_pkg::ADR_MASK) begin
            mask_nxt = wb_dat_i[3:0];
        end
        if (wr && adr == wdt_pkg::ADR_CTRL) begin
            kick_sw_nxt = wb_dat_i[0];
        end
        status_nxt = status_nxt | ev;
        wdo_nxt = sup_nxt == wdt_pkg::SUP_RUN && wd_nxt != wdt_pkg::WD_FLT;
        rst_n_nxt = HAS_RST_OUT ? sup_nxt == wdt_pkg::SUP_RUN : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= wdt_pkg::STATUS_RST;
            mask_r <= wdt_pkg::MASK_RST;
            kick_sw_r <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            irq_o <= 1'b0;
            watchdog_fault_out_n_o <= 1'b0;
            reset_out_n_o <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            kick_sw_r <= kick_sw_nxt;
            wb_ack_o <= hit;
            wb_dat_o <= dat_nxt;
            irq_o <= |(status_nxt & mask_nxt);
            watchdog_fault_out_n_o <= wdo_nxt;
            reset_out_n_o <= rst_n_nxt;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int FILT_N = wdt_pkg::FILT_CYC;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rd_last;
        sup_r == wdt_pkg::SUP_RDLY && sup_ok && rd_cnt_r == 3'h3 && rd_tick_r == RD_PERIOD - 20'd1;
    endsequence

    sequence s_outs_high;
        watchdog_fault_out_n_o && (reset_out_n_o || !HAS_RST_OUT);
    endsequence

    AST_RELEASE: assert property (s_rd_last |=> s_outs_high)
        else $error("outputs not high after four reset-delay cycles");
    AST_EN_START: assert property (run && wd_r == wdt_pkg::WD_IDLE && pin.enable
        |=> wd_r == wdt_pkg::WD_CHG && wd_cnt_r == 6'h0)
        else $error("enabled watchdog did not start");
    AST_IDLE_HOLD: assert property (run && wd_r == wdt_pkg::WD_IDLE && !pin.enable
        |=> wd_r == wdt_pkg::WD_IDLE)
        else $error("disabled watchdog left idle");
    AST_TIMEOUT: assert property (run && pin.enable && !qual && wd_r == wdt_pkg::WD_CHG
        && wd_cnt_r == 6'd31 && wd_tick_r == WD_PERIOD - 20'd1
        |=> wd_r == wdt_pkg::WD_FLT && !watchdog_fault_out_n_o)
        else $error("no fault after 32 cycles");
    AST_KICK: assert property (run && pin.enable && qual && !dp_hit && wd_r == wdt_pkg::WD_CHG
        |=> wd_r == wdt_pkg::WD_DIS && wd_cnt_r == 6'h0)
        else $error("kick did not clear counter");
    AST_DIS_DONE: assert property (run && pin.enable && !qual && wd_r == wdt_pkg::WD_DIS
        && wd_tick_r == WD_DISCH - 20'd1 |=> wd_r == wdt_pkg::WD_CHG)
        else $error("discharge did not resume cycling");
    AST_EN_DROP: assert property (run && !pin.enable && wd_r == wdt_pkg::WD_CHG
        |=> wd_r == wdt_pkg::WD_DIS && wd_cnt_r == 6'h0)
        else $error("enable drop did not discharge");
    AST_DPULSE: assert property (run && pin.enable && dp_hit && wd_r != wdt_pkg::WD_IDLE
        && wd_r != wdt_pkg::WD_FLT |=> !watchdog_fault_out_n_o)
        else $error("double pulse not flagged");
    AST_WIN_CLR: assert property (run && !pin.enable |=> dp_r == 20'd0)
        else $error("window survived enable drop");
    AST_BOTH_ORDER: assert property (dp_hit && EDGE_SEL == wdt_pkg::EDGE_BOTH
        |-> k_fall && last_rise_r)
        else $error("double pulse in wrong edge order");
    AST_LVD: assert property (!sup_ok |=> sup_r == wdt_pkg::SUP_LOW
        && !watchdog_fault_out_n_o && (!reset_out_n_o || !HAS_RST_OUT))
        else $error("low voltage did not pull outputs low");
    AST_FILT: assert property ($changed(flt_r[1]) |-> $past(s2_r[1], 1) == flt_r[1]
        && $past(s2_r[1], FILT_N) == flt_r[1])
        else $error("kick filter passed a short pulse");
    AST_INIT_WAIT: assert property (sup_r == wdt_pkg::SUP_INIT && !rd_dis_done
        |=> sup_r != wdt_pkg::SUP_RDLY)
        else $error("reset delay began before discharge done");

endmodule // supervisory_watchdog_with_reset

`default_nettype wire

/* File: tb/host_kicker.sv */
`default_nettype none

module host_kicker (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset, high
    input wire logic auto_i, // Periodic kicking on
    input wire logic [15:0] period_i, // Kick interval minus one cycle
    input wire logic fire_i, // One pulse on request
    input wire logic [7:0] width_i, // Pulse high time
    output logic kick_o // Kick pin
);
    // ----------------------------------------
    // Pulse timing
    // ----------------------------------------
    logic [15:0] gap_r;
    logic [7:0] hi_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_r <= 16'h0;
            hi_r <= 8'h0;
        end else begin
            gap_r <= (auto_i && gap_r < period_i) ? gap_r + 16'h1 : 16'h0;
            if (fire_i || (auto_i && gap_r == period_i)) begin
                hi_r <= width_i;
            end else if (hi_r != 8'h0) begin
                hi_r <= hi_r - 8'h1;
            end
        end
    end

    assign kick_o = (hi_r != 8'h0);
endmodule // host_kicker

`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RDP = 20;
    localparam int WDP = 64;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic supply_ok = 1'b1;
    logic enable = 1'b0;
    logic mode = 1'b1;
    logic kick;
    logic wdo_n;
    logic rst_n;
    logic irq;
    logic auto = 1'b0;
    logic fire = 1'b0;
    logic [7:0] width = 8'h1e;
    logic [15:0] period = 16'h100;
    logic [31:0] rd;
    int n;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 32'h7e08;

    supervisory_watchdog_with_reset #(.EDGE_SEL(wdt_pkg::EDGE_RISE), .HAS_RST_OUT(1'b0),
        .RD_PERIOD(20'(RDP)), .WD_PERIOD(20'(WDP)), .WD_DISCH(20'h4), .RD_DISCH(20'h4),
        .INIT_PERIOD(20'h8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .supply_ok_i(supply_ok), .enable_i(enable), .watchdog_kick_in_i(kick),
        .mode_timeout_i(mode), .watchdog_fault_out_n_o(wdo_n), .reset_out_n_o(rst_n), .irq_o(irq));

    host_kicker host (.clk_i(clk_i), .rst_i(rst_i), .auto_i(auto), .period_i(period),
        .fire_i(fire), .width_i(width), .kick_o(kick));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (i >= 20) begin
            chk(32'h0, 32'h1);
            test_done();
        end
    endtask

    task automatic wait_wdo(input logic exp, input int bound);
        n = 0;
        while (wdo_n !== exp && n < bound) begin
            @(posedge clk_i);
            n++;
        end
        if (wdo_n !== exp) begin
            chk({31'h0, wdo_n}, {31'h0, exp});
            test_done();
        end
    endtask

    task automatic hold_wdo(input logic exp, input int k);
        logic bad;
        bad = 1'b0;
        repeat (k) begin
            @(posedge clk_i);
            bad = bad | (wdo_n !== exp);
        end
        chk({31'h0, bad}, 32'h0);
    endtask

    task automatic pulse(input logic [7:0] w);
        @(posedge clk_i);
        width <= w;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_wdo(1'b1, 200);
        chk(32'(n >= 4 * RDP), 32'h1);
        chk({31'h0, rst_n}, 32'h1);
        wb(1'b0, wdt_pkg::ADR_MASK, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, wdt_pkg::ADR_STATUS, 32'h0);
        chk(rd & 32'h8, 32'h8);
        wb(1'b0, wdt_pkg::ADR_STATE, 32'h0);
        chk(rd & 32'hf, 32'h2);
        enable <= 1'b1;
        repeat (40) @(posedge clk_i);
        wb(1'b0, wdt_pkg::ADR_STATE, 32'h0);
        chk(rd & 32'hc, 32'h4);
        period <= 16'd200 + 16'($random(seed) & 511);
        auto <= 1'b1;
        hold_wdo(1'b1, 3000);
        auto <= 1'b0;
        enable <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb(1'b0, wdt_pkg::ADR_STATE, 32'h0);
        chk(rd & 32'h3f0, 32'h0);
        wb(1'b1, wdt_pkg::ADR_STATUS, 32'hf);
        wb(1'b1, wdt_pkg::ADR_MASK, 32'h1);
        enable <= 1'b1;
        wait_wdo(1'b0, 2200);
        chk(32'(n >= 32 * WDP && n <= 32 * WDP + 40), 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, wdt_pkg::ADR_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        wait_wdo(1'b1, 4 * RDP + 20);
        wb(1'b1, wdt_pkg::ADR_CTRL, 32'h1);
        wb(1'b0, wdt_pkg::ADR_STATE, 32'h0);
        chk(rd & 32'h3fc, 32'hc);
        wb(1'b1, wdt_pkg::ADR_MASK, 32'h0);
        mode <= 1'b0;
        repeat (40) @(posedge clk_i);
        pulse(8'h1e);
        repeat (58) @(posedge clk_i);
        pulse(8'h1e);
        wait_wdo(1'b0, 120);
        wb(1'b0, wdt_pkg::ADR_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wait_wdo(1'b1, 4 * RDP + 20);
        wb(1'b1, wdt_pkg::ADR_STATUS, 32'hf);
        repeat (100) @(posedge clk_i);
        pulse(8'h1e);
        repeat (38) @(posedge clk_i);
        pulse(8'h14);
        hold_wdo(1'b1, 200);
        pulse(8'h1e);
        repeat (5) @(posedge clk_i);
        enable <= 1'b0;
        repeat (30) @(posedge clk_i);
        enable <= 1'b1;
        repeat (23) @(posedge clk_i);
        pulse(8'h1e);
        hold_wdo(1'b1, 200);
        mode <= 1'b1;
        supply_ok <= 1'b0;
        enable <= 1'b0;
        wait_wdo(1'b0, 8);
        hold_wdo(1'b0, 40);
        supply_ok <= 1'b1;
        wait_wdo(1'b1, 4 * RDP + 50);
        chk(32'(n >= 4 * RDP), 32'h1);
        wb(1'b0, wdt_pkg::ADR_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, wdt_pkg::ADR_CTRL, 32'h0);
        chk(rd, 32'h0);
        n = $random(seed) & 15;
        wb(1'b1, wdt_pkg::ADR_MASK, 32'(n));
        wb(1'b0, wdt_pkg::ADR_MASK, 32'h0);
        chk(rd, 32'(n));
        test_done();
    end
endmodule // tb_top

`default_nettype wire
